// [hcr_pkg.sv]
package hcr_pkg;
	// Bus widths
	localparam int HADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int SD_ADDR_W = 13;
	localparam int SD_COL_W = 10;
	localparam int SD_BANK_W = 2;
	localparam int NVM_ADDR_W = 19;
	localparam int NVM_BURST_W = 4;
	localparam int CTL_ADDR_W = 8;
	localparam int NSLAVE = 3;
	// Host bit numbering is MSB-first: host bit n sits at vector index 31-n
	localparam int HOST_MSB_IDX = 31;
	// Host bit carrying SDRAM A0 for row and for column phase
	localparam int SD_ROW_BASE = 17;
	localparam int SD_COL_BASE = 29;
	// SDRAM precharge position and host bit it mirrors
	localparam int SD_PRE_BIT = 10;
	localparam int SD_PRE_HOST = 7;
	// NVM bit i (i >= 4) takes host bit NVM_HI_BASE - i
	localparam int NVM_HI_BASE = 34;
	// Control logic bit i takes host bit CTL_HOST_BASE - i
	localparam int CTL_HOST_BASE = 31;
	// Slave return select codes
	localparam logic [1:0] SEL_DRAM = 2'h0;
	localparam logic [1:0] SEL_NVM = 2'h1;
	localparam logic [1:0] SEL_CTRL = 2'h2;
	// Slave index in enable vectors
	localparam int IDX_DRAM = 0;
	localparam int IDX_NVM = 1;
	localparam int IDX_CTRL = 2;
	// Reset values
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;
	localparam logic [63:0] DATA_RST = 64'h0000_0000_0000_0000;
	localparam logic [2:0] OE_RST = 3'h0;

	// Direction and select controls from the external control logic
	typedef struct packed {
		logic drive_en;
		logic [1:0] sel;
		logic [2:0] wr_en;
	} hcr_ctrl_type;

	// Host bit n of an MSB-first address
	function automatic logic hbit(input logic [31:0] a, input int n);
		hbit = a[HOST_MSB_IDX - n];
	endfunction
endpackage

// [hcr_router.sv]
// Summary of operation
// R01: Latch host address on strobe, forward stable.
// R02: Each slave gets only its needed bits.
// R03: Host address input is 32 bits wide.
// R04: SDRAM: 10 column and 13 row bits.
// R05: Row/column select picks SDRAM address phase.
// R06: Two extra row bits bypass the mux.
// R07: Row A0..A12 from host bits 17..5, except A10, which comes from the precharge input.
// R08: A0 from bit 17 row, 29 column.
// R09: A10 always from host precharge output.
// R10: Two bank selects pick one of four.
// R11: Host should bank-select on low bits.
// R12: NVM bits 4-18 from host 16-30.
// R13: NVM bits 0-3 from burst lines, unlatched.
// R14: NVM data port is full 64 bits.
// R15: Control logic enables; data one direction only.
// R16: Read returns exactly one selected slave's data.
// R17: Drive host only while drive enable high.
// R18: Write drives only enabled slave bus.
// R19: Any bit routable to any bit by wiring.
// R20: All host address lines are inputs; host data is bidirectional.
// R21: Undriven ports have output enable low.
`timescale 1ns/1ps
`default_nettype none
module hcr_router (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// Host address side
	input wire logic ale_in,
	input wire logic [hcr_pkg::HADDR_W-1:0] host_address_in,
	input wire logic [hcr_pkg::NVM_BURST_W-1:0] host_burst_addr_in,
	input wire logic [hcr_pkg::SD_BANK_W-1:0] host_bank_select_in,
	input wire logic sdram_row_col_select_in,
	input wire logic sdram_precharge_addr_in,
	// Control logic steering
	input wire hcr_pkg::hcr_ctrl_type ctrl_in,
	// Host data port
	input wire logic [hcr_pkg::DATA_W-1:0] host_data_port_in,
	output logic [hcr_pkg::DATA_W-1:0] host_data_port_out,
	output logic host_data_port_oe_out,
	output logic host_data_valid_out,
	input wire logic host_data_ready_in,
	output logic read_ready_out,
	// SDRAM side
	output logic [hcr_pkg::SD_ADDR_W-1:0] dram_address_out,
	output logic [hcr_pkg::SD_BANK_W-1:0] dram_bank_out,
	input wire logic [hcr_pkg::DATA_W-1:0] dram_data_in,
	output logic [hcr_pkg::DATA_W-1:0] dram_data_out,
	output logic dram_data_oe_out,
	// NVM side
	output logic [hcr_pkg::NVM_ADDR_W-1:0] nvm_address_out,
	input wire logic [hcr_pkg::DATA_W-1:0] nvm_data_port_in,
	output logic [hcr_pkg::DATA_W-1:0] nvm_data_port_out,
	output logic nvm_data_port_oe_out,
	// Control logic device side
	output logic [hcr_pkg::CTL_ADDR_W-1:0] ctrl_logic_address_out,
	input wire logic [hcr_pkg::DATA_W-1:0] ctrl_logic_data_port_in,
	output logic [hcr_pkg::DATA_W-1:0] ctrl_logic_data_port_out,
	output logic ctrl_logic_data_port_oe_out
);

	// Latched host address
	logic [31:0] addr_q;
	logic [31:0] addr_d;
	// Registered address outputs
	logic [12:0] sd_addr_q;
	logic [12:0] sd_addr_d;
	logic [1:0] bank_q;
	logic [18:0] nvm_addr_q;
	logic [18:0] nvm_addr_d;
	logic [7:0] ctl_addr_q;
	logic [7:0] ctl_addr_d;
	// Write path flops, one per slave
	logic [63:0] wr_data_q [3];
	logic [2:0] wr_oe_q;
	// Read skid buffer: output stage plus one spare entry
	logic [63:0] out_q;
	logic [63:0] out_d;
	logic out_vld_q;
	logic out_vld_d;
	logic [63:0] skid_q;
	logic [63:0] skid_d;
	logic skid_vld_q;
	logic skid_vld_d;
	logic in_rdy_q;
	logic host_oe_q;
	// Read mux result and handshake terms
	logic [63:0] rd_word;
	logic push;
	logic pop;

	// Latch is transparent in the strobe cycle so outputs lag by one edge only
	always_comb
	begin
		addr_d = ale_in ? host_address_in : addr_q; // R01 R03 R20
	end

	// Address latch
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			addr_q <= hcr_pkg::ADDR_RST;
		else if (ce_in)
			addr_q <= addr_d; // R01
	end

	// SDRAM address crossbar; bit order swap is pure wiring via hbit
	genvar k;
	generate
		for (k = 0; k < hcr_pkg::SD_ADDR_W; k++)
		begin : g_sd
			if (k == hcr_pkg::SD_PRE_BIT)
			begin : g_pre
				// Precharge never passes the mux
				assign sd_addr_d[k] = sdram_precharge_addr_in; // R09
			end
			else if (k >= hcr_pkg::SD_COL_W)
			begin : g_byp
				// Row bits beyond the column count skip the mux
				assign sd_addr_d[k] = hcr_pkg::hbit(addr_d, hcr_pkg::SD_ROW_BASE - k); // R06 R07
			end
			else
			begin : g_mux
				// High select gives the column phase
				assign sd_addr_d[k] = sdram_row_col_select_in ?
					hcr_pkg::hbit(addr_d, hcr_pkg::SD_COL_BASE - k) :
					hcr_pkg::hbit(addr_d, hcr_pkg::SD_ROW_BASE - k); // R04 R05 R07 R08 R19
			end
		end
	endgenerate

	// NVM address: upper bits latched, burst bits straight from host
	genvar f;
	generate
		for (f = 0; f < hcr_pkg::NVM_ADDR_W; f++)
		begin : g_nvm
			if (f < hcr_pkg::NVM_BURST_W)
			begin : g_burst
				assign nvm_addr_d[f] = host_burst_addr_in[f]; // R13
			end
			else
			begin : g_hi
				assign nvm_addr_d[f] = hcr_pkg::hbit(addr_d, hcr_pkg::NVM_HI_BASE - f); // R12 R19
			end
		end
	endgenerate

	// Control logic address: lowest host byte only
	genvar c;
	generate
		for (c = 0; c < hcr_pkg::CTL_ADDR_W; c++)
		begin : g_ctl
			assign ctl_addr_d[c] = hcr_pkg::hbit(addr_d, hcr_pkg::CTL_HOST_BASE - c); // R02
		end
	endgenerate

	// Address output registers
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			sd_addr_q <= 13'h0000;
			bank_q <= 2'h0;
			nvm_addr_q <= 19'h0_0000;
			ctl_addr_q <= 8'h00;
		end
		else if (ce_in)
		begin
			sd_addr_q <= sd_addr_d; // R02
			bank_q <= host_bank_select_in; // R10
			nvm_addr_q <= nvm_addr_d; // R02
			ctl_addr_q <= ctl_addr_d;
		end
	end

	// Write path: a read in progress blocks every slave driver
	genvar s;
	generate
		for (s = 0; s < hcr_pkg::NSLAVE; s++)
		begin : g_wr
			always_ff @(posedge clk_in)
			begin
				if (sys_rst_in)
				begin
					wr_data_q[s] <= hcr_pkg::DATA_RST;
					wr_oe_q[s] <= 1'b0; // R21
				end
				else if (ce_in)
				begin
					wr_data_q[s] <= host_data_port_in; // R14
					wr_oe_q[s] <= ctrl_in.wr_en[s] & ~ctrl_in.drive_en; // R15 R18 R21
				end
			end
		end
	endgenerate

	// Read mux; unused select code returns zero
	always_comb
	begin
		if (ctrl_in.sel == hcr_pkg::SEL_DRAM)
			rd_word = dram_data_in; // R16
		else if (ctrl_in.sel == hcr_pkg::SEL_NVM)
			rd_word = nvm_data_port_in;
		else if (ctrl_in.sel == hcr_pkg::SEL_CTRL)
			rd_word = ctrl_logic_data_port_in;
		else
			rd_word = hcr_pkg::DATA_RST;
	end

	// Handshakes; ready is registered, so the spare entry absorbs one stall
	assign push = ctrl_in.drive_en & in_rdy_q;
	assign pop = out_vld_q & host_data_ready_in;

	// Skid buffer next state
	always_comb
	begin
		out_d = out_q;
		out_vld_d = out_vld_q;
		skid_d = skid_q;
		skid_vld_d = skid_vld_q;
		if (!out_vld_q || pop)
		begin
			// Output stage free: refill from spare first to keep order
			if (skid_vld_q)
			begin
				out_d = skid_q;
				out_vld_d = 1'b1;
				skid_vld_d = 1'b0;
			end
			else if (push)
			begin
				out_d = rd_word;
				out_vld_d = 1'b1;
			end
			else
				out_vld_d = 1'b0;
		end
		else if (push)
		begin
			// Receiver stalled: park the word
			skid_d = rd_word;
			skid_vld_d = 1'b1;
		end
	end

	// Skid buffer registers
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			out_q <= hcr_pkg::DATA_RST;
			out_vld_q <= 1'b0;
			skid_q <= hcr_pkg::DATA_RST;
			skid_vld_q <= 1'b0;
			in_rdy_q <= 1'b1;
			host_oe_q <= 1'b0;
		end
		else if (ce_in)
		begin
			out_q <= out_d;
			out_vld_q <= out_vld_d;
			skid_q <= skid_d;
			skid_vld_q <= skid_vld_d;
			in_rdy_q <= ~skid_vld_d;
			host_oe_q <= ctrl_in.drive_en & out_vld_d; // R15 R17 R21
		end
	end

	// Outputs straight from flops
	assign host_data_port_out = out_q;
	assign host_data_port_oe_out = host_oe_q;
	assign host_data_valid_out = out_vld_q;
	assign read_ready_out = in_rdy_q;
	assign dram_address_out = sd_addr_q;
	assign dram_bank_out = bank_q;
	assign dram_data_out = wr_data_q[hcr_pkg::IDX_DRAM];
	assign dram_data_oe_out = wr_oe_q[hcr_pkg::IDX_DRAM];
	assign nvm_address_out = nvm_addr_q;
	assign nvm_data_port_out = wr_data_q[hcr_pkg::IDX_NVM];
	assign nvm_data_port_oe_out = wr_oe_q[hcr_pkg::IDX_NVM];
	assign ctrl_logic_address_out = ctl_addr_q;
	assign ctrl_logic_data_port_out = wr_data_q[hcr_pkg::IDX_CTRL];
	assign ctrl_logic_data_port_oe_out = wr_oe_q[hcr_pkg::IDX_CTRL];

	// Checks
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	// Attempts that start in a reset cycle are skipped: the flops take reset values there
	AST_ALE_LATCH: assert property (!sys_rst_in && ce_in && ale_in // R01
		|=> addr_q == $past(host_address_in))
		else $error("address not latched on strobe");
	AST_ADDR_HOLD: assert property (ce_in && !ale_in |=> $stable(addr_q)) // R01
		else $error("address moved without strobe");
	AST_A0_ROW: assert property (ce_in && !sdram_row_col_select_in
		|=> dram_address_out[0] == addr_q[31 - 17]) // R08
		else $error("row A0 wrong");
	AST_A0_COL: assert property (ce_in && sdram_row_col_select_in
		|=> dram_address_out[0] == addr_q[31 - 29]) // R05
		else $error("column A0 wrong");
	AST_PRECHARGE: assert property (!sys_rst_in && ce_in // R09
		|=> dram_address_out[10] == $past(sdram_precharge_addr_in))
		else $error("precharge bit wrong");
	AST_BYPASS: assert property (ce_in
		|=> dram_address_out[12:11] == {addr_q[31 - 5], addr_q[31 - 6]}) // R06
		else $error("bypassed row bits wrong");
	AST_BANK: assert property (!sys_rst_in && ce_in // R10
		|=> dram_bank_out == $past(host_bank_select_in))
		else $error("bank select wrong");
	AST_NVM_HI: assert property (ce_in
		|=> nvm_address_out[18] == addr_q[31 - 16] && nvm_address_out[4] == addr_q[31 - 30]) // R12
		else $error("nvm upper address wrong");
	AST_NVM_BURST: assert property (!sys_rst_in && ce_in // R13
		|=> nvm_address_out[3:0] == $past(host_burst_addr_in))
		else $error("burst bits wrong");
	AST_ONE_DIR: assert property (!(host_data_port_oe_out && (|wr_oe_q))) // R15
		else $error("both directions driven");
	AST_WR_OE: assert property (!sys_rst_in && ce_in // R18
		|=> wr_oe_q == $past(ctrl_in.wr_en & {3{!ctrl_in.drive_en}}))
		else $error("slave enable wrong");
	AST_DRIVE: assert property (ce_in |=> !host_data_port_oe_out || $past(ctrl_in.drive_en)) // R17
		else $error("host driven without enable");
	AST_READ_SEL: assert property (!sys_rst_in && ce_in && push && !out_vld_q && !skid_vld_q // R16
		&& ctrl_in.sel == hcr_pkg::SEL_NVM |=> out_q == $past(nvm_data_port_in))
		else $error("wrong slave returned");
	AST_NO_LOSS: assert property (!sys_rst_in && ce_in && out_vld_q && !host_data_ready_in // R16
		|=> out_vld_q && $stable(out_q))
		else $error("stalled word lost");

	COV_READ: cover property (ce_in && push ##1 host_data_port_oe_out);
	COV_STALL_FULL: cover property (skid_vld_q && !read_ready_out);
	COV_COL_PHASE: cover property (ce_in && ale_in ##1 ce_in && sdram_row_col_select_in);
	COV_NVM_WRITE: cover property (nvm_data_port_oe_out);
endmodule
`default_nettype wire

// [hcr_slave_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Far side: three slaves driving read words toward the router
module hcr_slave_model #(
	parameter logic [63:0] DRAM_WORD = 64'hd0d0_1111_2222_3333,
	parameter logic [63:0] NVM_WORD = 64'h5a5a_4444_5555_6666,
	parameter logic [63:0] CTRL_WORD = 64'hc3c3_7777_8888_9999
) (
	// Clock
	input wire logic clk_in,
	// Router write enables toward each slave
	input wire logic dram_oe_in,
	input wire logic nvm_oe_in,
	input wire logic ctrl_oe_in,
	// Slave read data
	output logic [63:0] dram_data_out,
	output logic [63:0] nvm_data_out,
	output logic [63:0] ctrl_data_out
);
	// A slave whose bus the router drives stops driving it; its
	// lines then toggle so a stale word still shows on every second cycle
	always_ff @(posedge clk_in)
	begin
		dram_data_out <= dram_oe_in ? ~dram_data_out : DRAM_WORD;
		nvm_data_out <= nvm_oe_in ? ~nvm_data_out : NVM_WORD;
		ctrl_data_out <= ctrl_oe_in ? ~ctrl_data_out : CTRL_WORD;
	end
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// Stimulus
	logic clk_in = 0, sys_rst_in = 1, ce_in = 1, ale_in = 0, rc = 0, pre = 0, hready = 1;
	logic [31:0] addr = 32'h0000_0000;
	logic [3:0] burst = 4'h0;
	logic [1:0] bank = 2'h0;
	hcr_pkg::hcr_ctrl_type ctl = '0;
	logic [63:0] hdata = 64'h0000_0000_0000_0000;
	// Observed outputs
	logic [63:0] h_out, d_out, n_out, c_out, d_in, n_in, c_in;
	logic h_oe, h_vld, rd_rdy, d_oe, n_oe, c_oe;
	logic [12:0] d_addr;
	logic [1:0] d_bank;
	logic [18:0] n_addr;
	logic [7:0] c_addr;
	logic [63:0] words [4];
	int bad_count = 0, compares = 0, cyc = 0;
	hcr_router dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .ale_in(ale_in),
		.host_address_in(addr), .host_burst_addr_in(burst), .host_bank_select_in(bank),
		.sdram_row_col_select_in(rc), .sdram_precharge_addr_in(pre), .ctrl_in(ctl),
		.host_data_port_in(hdata), .host_data_port_out(h_out), .host_data_port_oe_out(h_oe),
		.host_data_valid_out(h_vld), .host_data_ready_in(hready), .read_ready_out(rd_rdy),
		.dram_address_out(d_addr), .dram_bank_out(d_bank), .dram_data_in(d_in),
		.dram_data_out(d_out), .dram_data_oe_out(d_oe), .nvm_address_out(n_addr),
		.nvm_data_port_in(n_in), .nvm_data_port_out(n_out), .nvm_data_port_oe_out(n_oe),
		.ctrl_logic_address_out(c_addr), .ctrl_logic_data_port_in(c_in),
		.ctrl_logic_data_port_out(c_out), .ctrl_logic_data_port_oe_out(c_oe));
	hcr_slave_model slave_u (.clk_in(clk_in), .dram_oe_in(d_oe), .nvm_oe_in(n_oe),
		.ctrl_oe_in(c_oe), .dram_data_out(d_in), .nvm_data_out(n_in), .ctrl_data_out(c_in));
	// Clock, 20 ns period
	initial
	begin
		forever #10 clk_in = ~clk_in;
	end
	// Hang guard, well above the run length
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			bad_count++;
			complete_run();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Lets the driving edge and the sampling edge pass
	task automatic cycle;
		@(posedge clk_in);
		@(negedge clk_in);
	endtask
	// Expected SDRAM address; host bit n sits at index 31-n
	function automatic logic [12:0] sd_exp(input logic [31:0] a, input logic col, input logic p);
		logic [12:0] r;
		for (int k = 0; k < 10; k++)
			r[k] = col ? a[31-(29-k)] : a[31-(17-k)];
		r[10] = p;
		r[11] = a[31-6];
		r[12] = a[31-5];
		return r;
	endfunction
	task automatic t_reset;
		@(posedge clk_in);
		sys_rst_in <= 1'b1;
		cycle();
		chk({d_addr, d_bank, n_addr, c_addr}, 64'h0000_0000_0000_0000);
		chk({h_oe, h_vld, d_oe, n_oe, c_oe, rd_rdy}, 64'h0000_0000_0000_0001);
		@(posedge clk_in);
		sys_rst_in <= 1'b0;
		$display("test reset done");
	endtask
	task automatic t_addr(input logic [31:0] a);
		@(posedge clk_in);
		ale_in <= 1'b1;
		addr <= a;
		rc <= 1'b0;
		pre <= ~a[0];
		burst <= a[7:4];
		cycle();
		chk(d_addr, sd_exp(a, 1'b0, ~a[0]));
		chk(n_addr, {a[15:1], a[7:4]});
		chk(c_addr, a[7:0]);
		@(posedge clk_in);
		ale_in <= 1'b0;
		addr <= ~a;
		rc <= 1'b1;
		burst <= ~a[7:4];
		cycle();
		chk(d_addr, sd_exp(a, 1'b1, ~a[0]));
		chk(n_addr, {a[15:1], ~a[7:4]});
		for (int b = 0; b < 4; b++)
		begin
			@(posedge clk_in);
			bank <= b[1:0];
			cycle();
			chk(d_bank, b);
		end
		$display("test address done");
	endtask
	// Clock enable low freezes every output; the strobe is ignored meanwhile
	task automatic t_hold;
		@(posedge clk_in);
		ce_in <= 1'b0;
		ale_in <= 1'b1;
		addr <= 32'h1234_5678;
		bank <= 2'h1;
		cycle();
		cycle();
		chk(c_addr, 64'h0000_0000_0000_00a5);
		chk(d_bank, 64'h0000_0000_0000_0003);
		@(posedge clk_in);
		ce_in <= 1'b1;
		cycle();
		chk(c_addr, 64'h0000_0000_0000_0078);
		chk(d_bank, 64'h0000_0000_0000_0001);
		@(posedge clk_in);
		ale_in <= 1'b0;
		$display("test hold done");
	endtask
	task automatic t_write;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk_in);
			ctl <= '{drive_en: 1'b0, sel: 2'h0, wr_en: 3'b001 << i};
			hdata <= 64'hf00d_0000_0000_0001 << i;
			cycle();
			chk({c_oe, n_oe, d_oe, h_oe}, 64'h1 << (i + 1));
			chk(d_out, 64'hf00d_0000_0000_0001 << i);
			chk(n_out, 64'hf00d_0000_0000_0001 << i);
			chk(c_out, 64'hf00d_0000_0000_0001 << i);
		end
		@(posedge clk_in);
		ctl <= '{drive_en: 1'b1, sel: 2'h0, wr_en: 3'b111};
		cycle();
		chk({c_oe, n_oe, d_oe}, 64'h0);
		$display("test write done");
	endtask
	task automatic t_read;
		words = '{d_in, n_in, c_in, 64'h0};
		for (int s = 0; s < 4; s++)
		begin
			@(posedge clk_in);
			ctl <= '{drive_en: 1'b1, sel: s[1:0], wr_en: 3'b000};
			cycle();
			chk(h_out, words[s]);
			chk({h_oe, h_vld}, 64'h3);
		end
		@(posedge clk_in);
		ctl <= '0;
		cycle();
		cycle();
		chk({h_oe, h_vld}, 64'h0);
		@(posedge clk_in);
		hready <= 1'b0;
		ctl <= '{drive_en: 1'b1, sel: 2'h1, wr_en: 3'b000};
		cycle();
		cycle();
		cycle();
		chk({rd_rdy, h_vld}, 64'h1);
		chk(h_out, words[1]);
		@(posedge clk_in);
		ctl <= '0;
		hready <= 1'b1;
		cycle();
		chk({rd_rdy, h_vld}, 64'h3);
		chk(h_out, words[1]);
		cycle();
		chk({rd_rdy, h_vld}, 64'h2);
		$display("test read done");
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_addr(32'ha5c3_3c5a);
		t_addr(32'h5a3c_c3a5);
		t_hold();
		t_write();
		t_read();
		t_reset();
		t_addr(32'hffff_0000);
		complete_run();
	end
endmodule
`default_nettype wire
